// ---- common/shape_regs_pkg.sv ----
// Purpose: Shared constants for the pulse-shape sample RAM register group.
// Assumes: Eight channels, 8-bit host register port, 7-bit signed samples.
// Notes:   Offsets are host register addresses on the control port.
package shape_regs_pkg;

  // Sizes
  localparam int CHANNELS  = 8;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 8;
  localparam int SAMPLE_W  = 7;
  localparam int INDEX_W   = 5;
  localparam int CHAN_W    = 3;

  // Sample store depth and unit-interval lengths
  localparam logic [4:0] DEPTH       = 5'h1c;
  localparam logic [4:0] UI_E1       = 5'h0c;
  localparam logic [4:0] UI_T1_SHORT = 5'h0d;
  localparam logic [4:0] UI_T1_LONG  = 5'h0e;
  localparam logic [4:0] INDEX_ZERO  = 5'h00;
  localparam logic [4:0] INDEX_ONE   = 5'h01;

  // Register offsets
  localparam logic [7:0] OFF_ALARM_FLAGS = 8'h15;
  localparam logic [7:0] OFF_BROADCAST   = 8'h16;
  localparam logic [7:0] OFF_POINTER     = 8'h17;
  localparam logic [7:0] OFF_SAMPLE      = 8'h18;
  localparam logic [7:0] OFF_SHAPE_SEL   = 8'h19;
  localparam logic [7:0] OFF_OVF_MASK    = 8'h1a;
  localparam logic [7:0] OFF_OVF_FLAGS   = 8'h1b;

  // Field layout of the sample pointer
  localparam int CHAN_LSB  = 5;
  localparam int CHAN_MSB  = 7;
  localparam int INDEX_MSB = 4;

  // Reset values and sample range
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [6:0] SAMPLE_ZERO = 7'h00;
  localparam logic [6:0] SAMPLE_MAX  = 7'h3f;
  localparam logic [6:0] SAMPLE_MIN  = 7'h40;

endpackage : shape_regs_pkg

// ---- rtl/sample_lane.sv ----
// Purpose: One channel's custom pulse sample store, playback and overflow scan.
// Assumes: Indices at or above the store depth are never used by software.
// Notes:   Store clears only on the power-up reset, never on the general reset.
`timescale 1ns/1ps
`default_nettype none

module sample_lane (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       por,
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_index,
  input  wire logic [6:0] wr_value,
  input  wire logic [4:0] rd_index,
  output logic      [6:0] rd_value,
  input  wire logic [4:0] tx_index,
  output logic      [6:0] tx_value,
  input  wire logic       e1_mode,
  input  wire logic       ui_long,
  output logic            overflow
);

  logic [6:0] mem [0:shape_regs_pkg::DEPTH-1];
  logic [4:0] ui_len;
  logic [4:0] scan_idx;
  logic [4:0] tail_idx;
  logic       scan_acc;
  logic [7:0] pair_sum;
  logic       pair_bad;

  // RULE_08 - survives software reset
  // RULE_09 - power-up clear only
  genvar e;
  generate
    for (e = 0; e < shape_regs_pkg::DEPTH; e++) begin : g_entry
      always_ff @(posedge clk) begin
        if (por) begin
          mem[e] <= shape_regs_pkg::SAMPLE_ZERO;
        end else if (wr_en && wr_index == 5'(e)) begin
          mem[e] <= wr_value;
        end
      end
    end
  endgenerate

  // RULE_06 - locations at or above the store depth read zero
  always_comb begin
    rd_value = (rd_index < shape_regs_pkg::DEPTH) ? mem[rd_index] : shape_regs_pkg::SAMPLE_ZERO;
  end

  // Samples per unit interval follow the line mode
  always_comb begin
    if (e1_mode) begin
      ui_len = shape_regs_pkg::UI_E1;
    end else if (ui_long) begin
      ui_len = shape_regs_pkg::UI_T1_LONG;
    end else begin
      ui_len = shape_regs_pkg::UI_T1_SHORT;
    end
  end

  // RULE_18 - lowest index first
  // RULE_19 - E1 drops tail
  always_comb begin
    if (tx_index >= ui_len && (e1_mode || tx_index >= 5'(ui_len << 1))) begin
      tx_value = shape_regs_pkg::SAMPLE_ZERO;
    end else begin
      tx_value = mem[tx_index];
    end
  end

  // RULE_17 - pairwise sum range check
  always_comb begin
    tail_idx = 5'(scan_idx + ui_len);
    pair_sum = {mem[scan_idx][6], mem[scan_idx]} + {mem[tail_idx][6], mem[tail_idx]};
    pair_bad = pair_sum[7] != pair_sum[6];
  end

  // Scan walks one pair per cycle; result updates once per full pass
  always_ff @(posedge clk) begin
    if (rst) begin
      scan_idx <= shape_regs_pkg::INDEX_ZERO;
      scan_acc <= 1'b0;
      overflow <= 1'b0;
    end else if (scan_idx >= ui_len - shape_regs_pkg::INDEX_ONE) begin
      scan_idx <= shape_regs_pkg::INDEX_ZERO;
      scan_acc <= 1'b0;
      overflow <= !e1_mode && (scan_acc || pair_bad);
    end else begin
      scan_idx <= scan_idx + shape_regs_pkg::INDEX_ONE;
      scan_acc <= scan_acc || pair_bad;
    end
  end

endmodule : sample_lane

`default_nettype wire

// ---- rtl/shape_ram_regs.sv ----
// Purpose: Host register group for custom pulse-shape RAM, alarm change flags
//          and overflow interrupt masking on an eight-channel line interface.
// Assumes: Host port strobes are one-cycle pulses synchronous to CLOCK.
// Notes:   Read data returns one cycle after the read strobe.
//
// Overview of operation
// RULE_01 - Each alarm status bit change sets its channel's change flag; code sets it only where AIS_IRQ_ENABLE is set.
// RULE_02 - Alarm change flags accumulate until the host clears them.
// RULE_03 - Sample writes go to every channel whose broadcast bit is set.
// RULE_04 - Pointer bits 7..5 choose the target channel for sample access.
// RULE_05 - Pointer bits 4..0 choose one of 24, 26 or 28 sample locations.
// RULE_06 - Host must not touch sample locations unused by the line mode.
// RULE_07 - Sample port writes store at the pointer; reads return that location.
// RULE_08 - Software reset leaves stored sample contents unchanged.
// RULE_09 - Sample contents clear to zero only at power-up.
// RULE_10 - Samples are 7-bit two's complement, 3Fh most positive, 40h most negative.
// RULE_11 - Host writes zero to bit 7 of the sample port.
// RULE_12 - Shape select bit set uses the channel's custom samples for transmit.
// RULE_13 - Shape select bit clear transmits the channel's fixed ROM shape.
// RULE_14 - Overflow mask bit lets a channel's overflow change raise its flag and interrupt.
// RULE_15 - Flags, broadcast, pointer, shape select and overflow mask reset to zero.
// RULE_16 - Reading a flag register clears its flags and releases the interrupt.
// RULE_17 - Overflow when a pairwise sum of first and second interval leaves 7-bit range.
// RULE_18 - Lowest index transmits first; stored positive, inverted for negative pulses.
// RULE_19 - In E1 the second interval samples are ignored.
// RULE_20 - Interrupt output low while any enabled change flag is pending.
// RULE_21 - With no broadcast bits, writes reach only the pointed channel and location.
`timescale 1ns/1ps
`default_nettype none

module shape_ram_regs (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        POWER_UP_RST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  output logic             REG_RVALID,
  input  wire logic [7:0]  AIS_STATUS,
  input  wire logic [7:0]  AIS_IRQ_ENABLE,
  input  wire logic [7:0]  LINE_E1,
  input  wire logic [7:0]  LINE_UI14,
  input  wire logic [39:0] TX_INDEX,
  input  wire logic [7:0]  TX_NEGATIVE,
  input  wire logic [55:0] ROM_SAMPLE,
  output logic      [55:0] TX_SAMPLE,
  output logic      [7:0]  CUSTOM_SHAPE_ON,
  output logic             INT_N
);

  // Host-visible registers
  logic [7:0] alarm_change_flags;
  logic [7:0] sample_broadcast_mask;
  logic [7:0] sample_pointer;
  logic [7:0] custom_shape_select;
  logic [7:0] overflow_irq_mask;
  logic [7:0] overflow_change_flags;

  // Change detection history
  logic [7:0] ais_prev;
  logic [7:0] ovf_prev;

  // Per-channel lane wiring
  logic [7:0] lane_wr;
  logic [7:0] lane_ovf;
  logic [6:0] lane_rd [0:shape_regs_pkg::CHANNELS-1];
  logic [6:0] lane_tx [0:shape_regs_pkg::CHANNELS-1];

  // Decoded strobes and fields
  logic       wr_broadcast;
  logic       wr_pointer;
  logic       wr_sample;
  logic       wr_shape_sel;
  logic       wr_ovf_mask;
  logic       rd_alarm;
  logic       rd_ovf;
  logic       broadcast_any;
  logic [2:0] target_channel_field;
  logic [4:0] sample_index_field;
  logic [6:0] sample_value_field;
  logic [7:0] ais_change;
  logic [7:0] ovf_change;
  logic [7:0] next_alarm_flags;
  logic [7:0] next_ovf_flags;
  logic [7:0] next_rdata;

  // Address decode of the host strobes
  always_comb begin
    wr_broadcast = REG_WR && REG_ADDR == shape_regs_pkg::OFF_BROADCAST;
    wr_pointer   = REG_WR && REG_ADDR == shape_regs_pkg::OFF_POINTER;
    wr_sample    = REG_WR && REG_ADDR == shape_regs_pkg::OFF_SAMPLE;
    wr_shape_sel = REG_WR && REG_ADDR == shape_regs_pkg::OFF_SHAPE_SEL;
    wr_ovf_mask  = REG_WR && REG_ADDR == shape_regs_pkg::OFF_OVF_MASK;
    rd_alarm     = REG_RD && REG_ADDR == shape_regs_pkg::OFF_ALARM_FLAGS;
    rd_ovf       = REG_RD && REG_ADDR == shape_regs_pkg::OFF_OVF_FLAGS;
  end

  // RULE_04 - channel field
  // RULE_05 - sample index field
  // RULE_11 - reserved bit dropped
  always_comb begin
    target_channel_field = sample_pointer[shape_regs_pkg::CHAN_MSB:shape_regs_pkg::CHAN_LSB];
    sample_index_field   = sample_pointer[shape_regs_pkg::INDEX_MSB:0];
    sample_value_field   = REG_WDATA[shape_regs_pkg::SAMPLE_W-1:0];
    broadcast_any        = |sample_broadcast_mask;
  end

  // RULE_15 - writable registers reset
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sample_broadcast_mask <= shape_regs_pkg::REG_RESET;
      sample_pointer        <= shape_regs_pkg::REG_RESET;
      custom_shape_select   <= shape_regs_pkg::REG_RESET;
      overflow_irq_mask     <= shape_regs_pkg::REG_RESET;
    end else begin
      if (wr_broadcast) begin
        sample_broadcast_mask <= REG_WDATA;
      end
      if (wr_pointer) begin
        sample_pointer <= REG_WDATA;
      end
      if (wr_shape_sel) begin
        custom_shape_select <= REG_WDATA;
      end
      if (wr_ovf_mask) begin
        overflow_irq_mask <= REG_WDATA;
      end
    end
  end

  // Status history for edge detection; cleared so a pending level after
  // reset shows up as a change on the first clean cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ais_prev <= shape_regs_pkg::REG_RESET;
      ovf_prev <= shape_regs_pkg::REG_RESET;
    end else begin
      ais_prev <= AIS_STATUS;
      ovf_prev <= lane_ovf;
    end
  end

  // RULE_01 - alarm change detect
  // RULE_14 - overflow change gated
  always_comb begin
    ais_change = (AIS_STATUS ^ ais_prev) & AIS_IRQ_ENABLE;
    ovf_change = (lane_ovf ^ ovf_prev) & overflow_irq_mask;
  end

  // RULE_02 - flags accumulate
  // RULE_16 - read clears, set wins
  always_comb begin
    next_alarm_flags = (rd_alarm ? shape_regs_pkg::REG_RESET : alarm_change_flags) | ais_change;
    next_ovf_flags   = (rd_ovf ? shape_regs_pkg::REG_RESET : overflow_change_flags) | ovf_change;
  end

  // RULE_15 - flag registers reset
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      alarm_change_flags    <= shape_regs_pkg::REG_RESET;
      overflow_change_flags <= shape_regs_pkg::REG_RESET;
    end else begin
      alarm_change_flags    <= next_alarm_flags;
      overflow_change_flags <= next_ovf_flags;
    end
  end

  // RULE_20 - interrupt from pending flags
  // Driven from the next flag values so the pin tracks the flags cycle for cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      INT_N <= 1'b1;
    end else begin
      INT_N <= !(|(next_alarm_flags & AIS_IRQ_ENABLE) || |(next_ovf_flags & overflow_irq_mask));
    end
  end

  // RULE_03 - broadcast write select
  // RULE_21 - single target otherwise
  genvar g;
  generate
    for (g = 0; g < shape_regs_pkg::CHANNELS; g++) begin : g_chan
      assign lane_wr[g] = wr_sample &&
        (broadcast_any ? sample_broadcast_mask[g] : target_channel_field == 3'(g));

      // RULE_07 - indirect sample access
      sample_lane u_lane (
        .clk      (CLOCK),
        .rst      (RST),
        .por      (POWER_UP_RST),
        .wr_en    (lane_wr[g]),
        .wr_index (sample_index_field),
        .wr_value (sample_value_field),
        .rd_index (sample_index_field),
        .rd_value (lane_rd[g]),
        .tx_index (TX_INDEX[g*shape_regs_pkg::INDEX_W +: shape_regs_pkg::INDEX_W]),
        .tx_value (lane_tx[g]),
        .e1_mode  (LINE_E1[g]),
        .ui_long  (LINE_UI14[g]),
        .overflow (lane_ovf[g])
      );

      // RULE_12 - custom shape source
      // RULE_13 - ROM shape otherwise
      // RULE_18 - invert for negative
      // Negating the most negative code wraps to itself; shapes should avoid it
      always_ff @(posedge CLOCK) begin
        if (RST) begin
          TX_SAMPLE[g*shape_regs_pkg::SAMPLE_W +: shape_regs_pkg::SAMPLE_W] <=
            shape_regs_pkg::SAMPLE_ZERO;
        end else if (custom_shape_select[g]) begin
          TX_SAMPLE[g*shape_regs_pkg::SAMPLE_W +: shape_regs_pkg::SAMPLE_W] <=
            TX_NEGATIVE[g] ? 7'(-lane_tx[g]) : lane_tx[g];
        end else begin
          TX_SAMPLE[g*shape_regs_pkg::SAMPLE_W +: shape_regs_pkg::SAMPLE_W] <=
            TX_NEGATIVE[g]
              ? 7'(-ROM_SAMPLE[g*shape_regs_pkg::SAMPLE_W +: shape_regs_pkg::SAMPLE_W])
              : ROM_SAMPLE[g*shape_regs_pkg::SAMPLE_W +: shape_regs_pkg::SAMPLE_W];
        end
      end
    end
  endgenerate

  // Shape select mirrored out for the pulse synthesiser
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CUSTOM_SHAPE_ON <= shape_regs_pkg::REG_RESET;
    end else begin
      CUSTOM_SHAPE_ON <= wr_shape_sel ? REG_WDATA : custom_shape_select;
    end
  end

  // RULE_07 - read back sample
  // RULE_10 - 7-bit value, bit 7 zero
  always_comb begin
    unique case (REG_ADDR)
      shape_regs_pkg::OFF_ALARM_FLAGS: next_rdata = alarm_change_flags;
      shape_regs_pkg::OFF_BROADCAST:   next_rdata = sample_broadcast_mask;
      shape_regs_pkg::OFF_POINTER:     next_rdata = sample_pointer;
      shape_regs_pkg::OFF_SAMPLE:      next_rdata = {1'b0, lane_rd[target_channel_field]};
      shape_regs_pkg::OFF_SHAPE_SEL:   next_rdata = custom_shape_select;
      shape_regs_pkg::OFF_OVF_MASK:    next_rdata = overflow_irq_mask;
      shape_regs_pkg::OFF_OVF_FLAGS:   next_rdata = overflow_change_flags;
      default:                         next_rdata = shape_regs_pkg::REG_RESET;
    endcase
  end

  // Read data is held until the next read so slow hosts can sample it late
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      REG_RDATA  <= shape_regs_pkg::REG_RESET;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

endmodule : shape_ram_regs

`default_nettype wire

// ---- verif/shape_ram_regs_chk.sv ----
// Purpose: Port assertions for the pulse-shape register group.
// Assumes: One clock; RST synchronous, active high.
// Notes:   Bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module shape_ram_regs_chk (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        POWER_UP_RST,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        REG_RVALID,
  input wire logic [7:0]  AIS_STATUS,
  input wire logic [7:0]  AIS_IRQ_ENABLE,
  input wire logic [7:0]  LINE_E1,
  input wire logic [7:0]  LINE_UI14,
  input wire logic [39:0] TX_INDEX,
  input wire logic [7:0]  TX_NEGATIVE,
  input wire logic [55:0] ROM_SAMPLE,
  input wire logic [55:0] TX_SAMPLE,
  input wire logic [7:0]  CUSTOM_SHAPE_ON,
  input wire logic        INT_N
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Request and answer steps of the host port
  sequence s_read; REG_RD; endsequence
  sequence s_answer; REG_RVALID; endsequence
  sequence s_shape_wr; REG_WR && REG_ADDR == 8'h19; endsequence
  property p_answer; s_read |=> s_answer; endproperty
  property p_no_answer; !REG_RD |=> !REG_RVALID; endproperty
  property p_rdata_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
  property p_bit7; REG_RD && REG_ADDR == 8'h18 |=> !REG_RDATA[7]; endproperty
  property p_shape_wr; s_shape_wr |=> CUSTOM_SHAPE_ON == $past(REG_WDATA); endproperty
  property p_shape_hold;
    !(REG_WR && REG_ADDR == 8'h19) |=> $stable(CUSTOM_SHAPE_ON);
  endproperty
  property p_rom;
    CUSTOM_SHAPE_ON == 8'h00 && TX_NEGATIVE == 8'h00 |=> TX_SAMPLE == $past(ROM_SAMPLE);
  endproperty
  // History is cleared by reset, so the edge after release is left out
  property p_ais_int;
    !$past(RST) && ((AIS_STATUS ^ $past(AIS_STATUS)) & AIS_IRQ_ENABLE) != 8'h00 |=> !INT_N;
  endproperty
  // A mask or enable change may legally release the pin, so those cycles are left out
  property p_int_hold;
    !INT_N && !(REG_RD && (REG_ADDR == 8'h15 || REG_ADDR == 8'h1b)) &&
      !($past(REG_WR) && $past(REG_ADDR) == 8'h1a) && $stable(AIS_IRQ_ENABLE) |=> !INT_N;
  endproperty
  property p_reset;
    disable iff (1'b0)
    RST |=> INT_N && !REG_RVALID && CUSTOM_SHAPE_ON == 8'h00 && TX_SAMPLE == 56'h0;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  a_no_answer: assert property (p_no_answer) else $error("stray read valid");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_bit7: assert property (p_bit7) else $error("sample bit 7 set");
  a_shape_wr: assert property (p_shape_wr) else $error("shape select not written");
  a_shape_hold: assert property (p_shape_hold) else $error("shape select moved");
  a_rom: assert property (p_rom) else $error("rom sample not passed");
  a_ais_int: assert property (p_ais_int) else $error("alarm change not flagged");
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped early");
  a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule : shape_ram_regs_chk
bind shape_ram_regs shape_ram_regs_chk shape_ram_regs_chk_i (
  .CLOCK(CLOCK), .RST(RST), .POWER_UP_RST(POWER_UP_RST), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .AIS_STATUS(AIS_STATUS), .AIS_IRQ_ENABLE(AIS_IRQ_ENABLE),
  .LINE_E1(LINE_E1), .LINE_UI14(LINE_UI14), .TX_INDEX(TX_INDEX),
  .TX_NEGATIVE(TX_NEGATIVE), .ROM_SAMPLE(ROM_SAMPLE), .TX_SAMPLE(TX_SAMPLE),
  .CUSTOM_SHAPE_ON(CUSTOM_SHAPE_ON), .INT_N(INT_N));
`default_nettype wire

// ---- verif/host_model.sv ----
// Purpose: Host processor driving the register port.
// Assumes: Strobes are one-cycle pulses launched just after an edge.
// Notes:   Write data is inverted once released, so stale data never looks valid.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic            wr,
  output logic            rd,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  // Idle bus at time zero
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = (a == 8'h18) ? {1'b0, d[6:0]} : d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    wdata = ~wdata;
  endtask : wr_reg
  // Answer taken at the edge where valid is sampled
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    @(posedge clk);
    d = rvalid ? rdata : 8'hxx;
  endtask : rd_reg
endmodule : host_model
`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the pulse-shape register group.
// Assumes: Host model owns the register port.
// Notes:   Random values from a fixed-seed xorshift.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic [7:0]  ais, line_e1, neg, addr, wdata, rdata, shape_on, d, m, mask;
  logic [7:0]  ui14, ais_en;
  logic        wr, rd, rvalid, int_n;
  logic [39:0] tx_idx;
  logic [55:0] rom, tx;
  logic [6:0]  v [8];
  logic [31:0] seed = 32'h7f70f1b0;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [7:0]  rw_regs [4] = '{8'h16, 8'h17, 8'h19, 8'h1a};

  shape_ram_regs shape_ram_regs_i (.CLOCK(clk), .RST(rst), .POWER_UP_RST(por),
    .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .AIS_STATUS(ais), .AIS_IRQ_ENABLE(ais_en), .LINE_E1(line_e1),
    .LINE_UI14(ui14), .TX_INDEX(tx_idx), .TX_NEGATIVE(neg), .ROM_SAMPLE(rom),
    .TX_SAMPLE(tx), .CUSTOM_SHAPE_ON(shape_on), .INT_N(int_n));
  host_model host_model_i (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Transmit sample after polarity
  function automatic logic [6:0] shp(input logic [6:0] s, input logic n);
    return n ? 7'(-s) : s;
  endfunction : shp
  task automatic chk(input string n, input logic [55:0] e, input logic [55:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host_model_i.rd_reg(a, q);
    chk($sformatf("reg%h", a), 56'(e), 56'(q));
  endtask : rdc
  task automatic sw(input logic [2:0] c, input logic [4:0] i, input logic [6:0] s);
    host_model_i.wr_reg(8'h17, {c, i});
    host_model_i.wr_reg(8'h18, {1'b0, s});
  endtask : sw
  task automatic sr(input logic [2:0] c, input logic [4:0] i, input logic [6:0] s);
    host_model_i.wr_reg(8'h17, {c, i});
    rdc(8'h18, {1'b0, s});
  endtask : sr
  task automatic txchk(input logic cu, input logic [6:0] cv);
    repeat (2) @(posedge clk);
    for (int c = 0; c < 8; c++) begin
      chk("tx", 56'(shp(cu ? cv : rom[7*c +: 7], neg[c])), 56'(tx[7*c +: 7]));
    end
  endtask : txchk
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  always #2 clk = ~clk;
  // Hang guard, far above the roughly five hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    ais = 8'h00;
    ais_en = 8'hff;
    ui14 = 8'hff;
    line_e1 = 8'h00;
    neg = 8'h00;
    tx_idx = 40'h0;
    rom = 56'h0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    por = 1'b0;
    for (int r = 8'h15; r < 8'h1b; r++) rdc(8'(r), 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'(rnd());
      host_model_i.wr_reg(rw_regs[i % 4], d);
      rdc(rw_regs[i % 4], d);
    end
    host_model_i.wr_reg(8'h15, 8'hff);
    rdc(8'h15, 8'h00);
    rdc(8'h20, 8'h00);
    host_model_i.wr_reg(8'h16, 8'h00);
    for (int c = 0; c < 8; c++) begin
      v[c] = 7'(rnd());
      sw(3'(c), 5'd27, 7'h40);
      sw(3'(c), 5'd0, 7'h3f);
      sw(3'(c), 5'(c + 1), v[c]);
    end
    for (int c = 0; c < 8; c++) begin
      sr(3'(c), 5'd27, 7'h40);
      sr(3'(c), 5'd0, 7'h3f);
      sr(3'(c), 5'(c + 1), v[c]);
      sr(3'(c), 5'(c + 2), 7'h00);
    end
    mask = 8'(rnd()) | 8'h01;
    host_model_i.wr_reg(8'h16, mask);
    sw(3'd0, 5'd12, 7'h2a);
    host_model_i.wr_reg(8'h16, 8'h00);
    for (int c = 0; c < 8; c++) sr(3'(c), 5'd12, mask[c] ? 7'h2a : 7'h00);
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    // Pointer and shape select were left nonzero before the reset
    for (int r = 0; r < 4; r++) rdc(rw_regs[r], 8'h00);
    sr(3'd7, 5'd27, 7'h40);
    #1 rom = 56'({rnd(), rnd()});
    neg = 8'(rnd());
    txchk(1'b0, 7'h00);
    host_model_i.wr_reg(8'h19, 8'hff);
    chk("shape_on", 56'hff, 56'(shape_on));
    txchk(1'b1, 7'h3f);
    #1 tx_idx = {8{5'd27}};
    txchk(1'b1, 7'h40);
    #1 line_e1 = 8'hff;
    txchk(1'b1, 7'h00);
    #1 line_e1 = 8'h00;
    // Short T1 interval: index 27 is past the 26 used locations
    ui14 = 8'h00;
    txchk(1'b1, 7'h00);
    #1 ui14 = 8'hff;
    d = 8'(rnd()) | 8'h01;
    m = 8'(rnd());
    ais = d;
    repeat (2) @(posedge clk);
    #1 ais = m;
    repeat (2) @(posedge clk);
    chk("int_n", 56'h0, 56'(int_n));
    rdc(8'h15, d | (d ^ m));
    #1 chk("int_n", 56'h1, 56'(int_n));
    rdc(8'h15, 8'h00);
    // Disabled channels must not raise change flags
    #1 ais_en = 8'h00;
    ais = ~m;
    repeat (2) @(posedge clk);
    rdc(8'h15, 8'h00);
    #1 ais_en = 8'hff;
    host_model_i.wr_reg(8'h1a, 8'h01);
    sw(3'd0, 5'd14, 7'h3f);
    sw(3'd1, 5'd14, 7'h3f);
    repeat (40) @(posedge clk);
    chk("int_n", 56'h0, 56'(int_n));
    rdc(8'h1b, 8'h01);
    #1 chk("int_n", 56'h1, 56'(int_n));
    end_sim();
  end
endmodule : tb
`default_nettype wire
